// ==== eeprom_link_cfg.svh ====
`ifndef EEPROM_LINK_CFG_SVH
`define EEPROM_LINK_CFG_SVH

// select byte device-type codes, protection read byte, address reset value, bits per byte
`define TYPE_MEM        4'hA
`define TYPE_PROT       4'h6
`define PROT_READ_BYTE  8'hFF
`define ADDR_RESET      8'h00
`define BITS_PER_BYTE   4'h8

// host timing
`define SYS_CLK_NS      100
`define SCL_PERIOD_NS   2500
`define SCL_QUARTER_CYC ((`SCL_PERIOD_NS / 4 + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

// host register offsets
`define OFS_CMD         8'h00
`define OFS_TX          8'h04
`define OFS_STATUS      8'h08

// command register fields
`define CMD_START_BIT   0
`define CMD_STOP_BIT    1
`define CMD_READ_BIT    2
`define CMD_ACK_BIT     3
`define CMD_INHIBIT_BIT 4
`define CMD_RESET       32'h0000_0000

// status register fields
`define STAT_BUSY_BIT   0
`define STAT_NACK_BIT   1
`define STAT_RX_LSB     8

`endif

// ==== eeprom_link_pkg.sv ====
package eeprom_link_pkg;
  typedef enum logic [2:0] {DS_IDLE, DS_SEL, DS_ADDR, DS_WDATA, DS_READ, DS_RACK} dev_state_t;
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} host_state_t;
endpackage

// ==== two_wire_if.sv ====
interface two_wire_if;
  logic scl;           // serial clock, driven by the master only
  logic sdaOutHost;    // master data drive value
  logic sdaOeHost;     // master drives data line
  logic sdaOutDev;     // device data drive value
  logic sdaOeDev;      // device drives data line
  logic writeInhibit;  // write-inhibit input level
  logic sda;           // resolved open-drain level

  assign sda = !((sdaOeHost && !sdaOutHost) || (sdaOeDev && !sdaOutDev));

  modport host (output scl, output sdaOutHost, output sdaOeHost, output writeInhibit, input sda);
  modport dev  (input scl, output sdaOutDev, output sdaOeDev, input writeInhibit, input sda);
endinterface

// ==== eeprom_dev.sv ====
// Notes on behaviour
// [R1] lower half 00h-7Fh can be locked
// [R2] lock set by write, inhibit low
// [R3] protection select 0110 plus strap bits
// [R4] address and data bytes ignored
// [R5] lock permanent, regardless of inhibit
// [R6] locked: protection select not acknowledged
// [R7] 01100000b sets lock, then ignored
// [R8] reads ignore write-inhibit level
// [R9] random read: dummy write, restart, read
// [R10] random read: ack select, send byte
// [R11] current read: send counter byte, increment
// [R12] master ack continues sequential read
// [R13] counter increments, wraps to 00h
// [R14] no ack at 9th bit: standby
// [R15] unlocked: full access everywhere
// [R16] master writes data before locking
// [R17] memory selected by type 1010
// [R18] select lsb: 1 read, 0 write
// [R19] chip-select mismatch: standby
// [R20] protected write: no ack, unchanged
// [R21] lock nonvolatile (lock_r clears on rst_b); 8-bit counter
`include "eeprom_link_cfg.svh"
module eeprom_dev
  import eeprom_link_pkg::*;
#(
  parameter int DEPTH = 256
) (
  input  wire logic       sys_clk,       // system clock
  input  wire logic       rst_b,         // async reset, active low
  two_wire_if.dev         link,          // two-wire bus
  input  wire logic [2:0] chipSelStrap,  // chip-select strap pins
  output logic            lockState      // lower half locked
);

  initial begin
    if (DEPTH != 256) $error("eeprom_dev serves 256 locations only");
  end

  dev_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic       oe_r, oe_nxt;
  logic       inAck_r, inAck_nxt;
  logic       prot_r, prot_nxt;
  logic       lockPend_r, lockPend_nxt;
  logic       lock_r, lock_nxt;
  logic       sdaOut_r;
  logic [2:0] sclSync, sdaSync;
  logic [1:0] inhSync;
  logic [2:0] strapS1, strapS2;
  logic [7:0] mem [DEPTH];
  logic       memWe;
  logic [7:0] rdByte;
  logic       sclRise, sclFall, startSeen, stopSeen;
  logic       selHit, selProt, wrOk;

  // stage 0 only feeds stage 1; edges use stages 1 and 2
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclSync <= 3'h7;
      sdaSync <= 3'h7;
      inhSync <= 2'h3;
      strapS1 <= 3'h0;
      strapS2 <= 3'h0;
    end else begin
      sclSync <= {sclSync[1:0], link.scl};
      sdaSync <= {sdaSync[1:0], link.sda};
      inhSync <= {inhSync[0], link.writeInhibit};
      strapS1 <= chipSelStrap;
      strapS2 <= strapS1;
    end
  end

  assign sclRise   = sclSync[1] && !sclSync[2];
  assign sclFall   = !sclSync[1] && sclSync[2];
  assign startSeen = sclSync[1] && sclSync[2] && sdaSync[2] && !sdaSync[1];
  assign stopSeen  = sclSync[1] && sclSync[2] && !sdaSync[2] && sdaSync[1];

  assign selProt = (sh_r[7:4] == `TYPE_PROT) && !lock_r;                              // [R3] [R6] [R7]
  assign selHit  = (sh_r[3:1] == strapS2) && ((sh_r[7:4] == `TYPE_MEM) || selProt);  // [R17] [R19]
  // inhibit gates writes only; lower half guarded once locked
  assign wrOk    = !inhSync[1] && (prot_r || !(lock_r && !addr_r[7]));               // [R1] [R5] [R15] [R20]
  assign rdByte  = prot_r ? `PROT_READ_BYTE : mem[addr_r];                           // [R8]

  always_comb begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    sh_nxt       = sh_r;
    addr_nxt     = addr_r;
    oe_nxt       = oe_r;
    inAck_nxt    = inAck_r;
    prot_nxt     = prot_r;
    lockPend_nxt = lockPend_r;
    lock_nxt     = lock_r;
    memWe        = 1'b0;
    if (startSeen) begin
      // repeated start keeps the counter for random reads
      st_nxt       = DS_SEL;
      cnt_nxt      = 4'h0;
      oe_nxt       = 1'b0;
      inAck_nxt    = 1'b0;
      lockPend_nxt = 1'b0;
    end else if (stopSeen) begin
      st_nxt       = DS_IDLE;
      oe_nxt       = 1'b0;
      inAck_nxt    = 1'b0;
      lockPend_nxt = 1'b0;
      if (lockPend_r) begin
        lock_nxt = 1'b1;                                                             // [R2] [R5] [R21]
      end
    end else if (sclRise) begin
      case (st_r)
        DS_SEL, DS_ADDR, DS_WDATA: begin
          if (!inAck_r) begin
            sh_nxt  = {sh_r[6:0], sdaSync[1]};
            cnt_nxt = cnt_r + 4'h1;
          end
        end
        DS_READ: begin
          sh_nxt  = {sh_r[6:0], 1'b1};
          cnt_nxt = cnt_r + 4'h1;
        end
        DS_RACK: begin
          if (sdaSync[1]) begin
            st_nxt = DS_IDLE;                                                        // [R14]
          end
        end
        default: ;
      endcase
    end else if (sclFall) begin
      case (st_r)
        DS_SEL: begin
          if (inAck_r) begin
            inAck_nxt = 1'b0;
            cnt_nxt   = 4'h0;
            oe_nxt    = 1'b0;
            if (sh_r[0]) begin                                                       // [R18]
              st_nxt = DS_READ;                                                      // [R10] [R11]
              sh_nxt = rdByte;
              oe_nxt = !rdByte[7];
            end else begin
              st_nxt = DS_ADDR;
            end
          end else if (cnt_r == `BITS_PER_BYTE) begin
            if (selHit) begin
              oe_nxt    = 1'b1;
              inAck_nxt = 1'b1;
              prot_nxt  = sh_r[7:4] == `TYPE_PROT;
            end else begin
              st_nxt = DS_IDLE;                                                      // [R19] [R6]
            end
          end
        end
        DS_ADDR: begin
          if (inAck_r) begin
            inAck_nxt = 1'b0;
            cnt_nxt   = 4'h0;
            oe_nxt    = 1'b0;
            st_nxt    = DS_WDATA;
          end else if (cnt_r == `BITS_PER_BYTE) begin
            oe_nxt    = 1'b1;
            inAck_nxt = 1'b1;
            if (!prot_r) begin
              addr_nxt = sh_r;                                                       // [R4] [R9]
            end
          end
        end
        DS_WDATA: begin
          if (inAck_r) begin
            inAck_nxt = 1'b0;
            cnt_nxt   = 4'h0;
            oe_nxt    = 1'b0;
          end else if (cnt_r == `BITS_PER_BYTE) begin
            if (wrOk) begin
              oe_nxt    = 1'b1;
              inAck_nxt = 1'b1;
              if (prot_r) begin
                lockPend_nxt = 1'b1;                                                 // [R2] [R4] [R7]
              end else begin
                memWe    = 1'b1;
                addr_nxt = addr_r + 8'h01;
              end
            end else begin
              st_nxt = DS_IDLE;                                                      // [R20]
            end
          end
        end
        DS_READ: begin
          if (cnt_r == `BITS_PER_BYTE) begin
            oe_nxt = 1'b0;
            st_nxt = DS_RACK;
            if (!prot_r) begin
              addr_nxt = addr_r + 8'h01;                                             // [R11] [R13] [R21]
            end
          end else begin
            oe_nxt = !sh_r[7];
          end
        end
        DS_RACK: begin
          st_nxt  = DS_READ;                                                         // [R12]
          cnt_nxt = 4'h0;
          sh_nxt  = rdByte;
          oe_nxt  = !rdByte[7];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r       <= DS_IDLE;
      cnt_r      <= 4'h0;
      sh_r       <= 8'h00;
      addr_r     <= `ADDR_RESET;
      oe_r       <= 1'b0;
      inAck_r    <= 1'b0;
      prot_r     <= 1'b0;
      lockPend_r <= 1'b0;
      lock_r     <= 1'b0;
      sdaOut_r   <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      sh_r       <= sh_nxt;
      addr_r     <= addr_nxt;
      oe_r       <= oe_nxt;
      inAck_r    <= inAck_nxt;
      prot_r     <= prot_nxt;
      lockPend_r <= lockPend_nxt;
      lock_r     <= lock_nxt;
      sdaOut_r   <= 1'b0;
    end
  end

  // array has no reset: contents stand in for nonvolatile cells
  always_ff @(posedge sys_clk) begin
    if (memWe) begin
      mem[addr_r] <= sh_r;
    end
  end

  assign link.sdaOeDev  = oe_r;
  assign link.sdaOutDev = sdaOut_r;
  assign lockState      = lock_r;

endmodule

// ==== eeprom_host.sv ====
`include "eeprom_link_cfg.svh"
module eeprom_host
  import eeprom_link_pkg::*;
#(
  parameter int QUARTER_CYC = `SCL_QUARTER_CYC
) (
  input  wire logic        sys_clk,   // system clock
  input  wire logic        rst_b,     // async reset, active low
  two_wire_if.host         link,      // two-wire bus
  input  wire logic        psel,      // apb select
  input  wire logic        penable,   // apb enable
  input  wire logic        pwrite,    // apb direction
  input  wire logic [7:0]  paddr,     // apb byte address
  input  wire logic [31:0] pwdata,    // apb write data
  output logic [31:0]      prdata,    // apb read data
  output logic             pready,    // apb ready
  output logic             pslverr    // apb error, unmapped address
);

  initial begin
    if (QUARTER_CYC < 4 || QUARTER_CYC > 255) $error("eeprom_host quarter count out of range");
  end

  host_state_t st_r, st_nxt;
  logic [7:0]  qCnt_r, qCnt_nxt;
  logic [1:0]  q_r, q_nxt;
  logic [3:0]  bitIdx_r, bitIdx_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic [7:0]  tx_r, tx_nxt;
  logic [31:0] cmd_r, cmd_nxt;
  logic        nack_r, nack_nxt;
  logic        scl_r, scl_nxt;
  logic        oe_r, oe_nxt;
  logic        rdy_r, rdy_nxt;
  logic        err_r, err_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [1:0]  sdaSync;
  logic        tick, access, isRead;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdaSync <= 2'h3;
    end else begin
      sdaSync <= {sdaSync[0], link.sda};
    end
  end

  assign tick   = (st_r != HS_IDLE) && (qCnt_r == 8'(QUARTER_CYC - 1));
  assign access = psel && penable && !rdy_r;
  assign isRead = cmd_r[`CMD_READ_BIT];

  always_comb begin
    st_nxt     = st_r;
    qCnt_nxt   = tick ? 8'h00 : qCnt_r + 8'h01;
    q_nxt      = q_r;
    bitIdx_nxt = bitIdx_r;
    sh_nxt     = sh_r;
    tx_nxt     = tx_r;
    cmd_nxt    = cmd_r;
    nack_nxt   = nack_r;
    scl_nxt    = scl_r;
    oe_nxt     = oe_r;
    rdy_nxt    = access;
    err_nxt    = 1'b0;
    rd_nxt     = rd_r;
    if (st_r == HS_IDLE) begin
      qCnt_nxt = 8'h00;
    end
    if (access) begin
      rd_nxt = 32'h0000_0000;
      case (paddr)
        `OFS_CMD: begin
          rd_nxt = cmd_r;
          if (pwrite && st_r == HS_IDLE) begin
            cmd_nxt    = pwdata;
            st_nxt     = pwdata[`CMD_START_BIT] ? HS_START : HS_BIT;
            q_nxt      = 2'h0;
            bitIdx_nxt = 4'h0;
            sh_nxt     = tx_r;
          end
        end
        `OFS_TX: begin
          rd_nxt = {24'h0, tx_r};
          if (pwrite) begin
            tx_nxt = pwdata[7:0];
          end
        end
        `OFS_STATUS: begin
          rd_nxt[`STAT_BUSY_BIT]             = st_r != HS_IDLE;
          rd_nxt[`STAT_NACK_BIT]             = nack_r;
          rd_nxt[`STAT_RX_LSB +: 8]          = sh_r;
        end
        default: err_nxt = 1'b1;
      endcase
    end
    if (tick) begin
      q_nxt = q_r + 2'h1;
      case (st_r)
        HS_START: begin
          case (q_r)
            2'h0: oe_nxt = 1'b0;
            2'h1: scl_nxt = 1'b1;
            2'h2: oe_nxt = 1'b1;
            default: begin
              scl_nxt = 1'b0;
              st_nxt  = HS_BIT;
            end
          endcase
        end
        HS_BIT: begin
          case (q_r)
            2'h0: begin
              if (bitIdx_r != 4'h8) begin
                oe_nxt = !isRead && !sh_r[7];
              end else begin
                oe_nxt = isRead && cmd_r[`CMD_ACK_BIT];              // [R10] [R11] [R12]
              end
            end
            2'h1: scl_nxt = 1'b1;
            2'h2: begin
              if (bitIdx_r != 4'h8) begin
                sh_nxt = {sh_r[6:0], sdaSync[1]};
              end else if (!isRead) begin
                nack_nxt = sdaSync[1];
              end
            end
            default: begin
              scl_nxt = 1'b0;
              if (bitIdx_r == 4'h8) begin
                st_nxt = cmd_r[`CMD_STOP_BIT] ? HS_STOP : HS_IDLE;  // [R9]
              end else begin
                bitIdx_nxt = bitIdx_r + 4'h1;
              end
            end
          endcase
        end
        HS_STOP: begin
          case (q_r)
            2'h0: oe_nxt = 1'b1;
            2'h1: scl_nxt = 1'b1;
            2'h2: oe_nxt = 1'b0;
            default: st_nxt = HS_IDLE;
          endcase
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r     <= HS_IDLE;
      qCnt_r   <= 8'h00;
      q_r      <= 2'h0;
      bitIdx_r <= 4'h0;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      cmd_r    <= `CMD_RESET;
      nack_r   <= 1'b0;
      scl_r    <= 1'b1;
      oe_r     <= 1'b0;
      rdy_r    <= 1'b0;
      err_r    <= 1'b0;
      rd_r     <= 32'h0000_0000;
    end else begin
      st_r     <= st_nxt;
      qCnt_r   <= qCnt_nxt;
      q_r      <= q_nxt;
      bitIdx_r <= bitIdx_nxt;
      sh_r     <= sh_nxt;
      tx_r     <= tx_nxt;
      cmd_r    <= cmd_nxt;
      nack_r   <= nack_nxt;
      scl_r    <= scl_nxt;
      oe_r     <= oe_nxt;
      rdy_r    <= rdy_nxt;
      err_r    <= err_nxt;
      rd_r     <= rd_nxt;
    end
  end

  assign link.scl          = scl_r;
  assign link.sdaOeHost    = oe_r;
  assign link.sdaOutHost   = 1'b0;
  assign link.writeInhibit = cmd_r[`CMD_INHIBIT_BIT];                 // [R2]
  assign prdata            = rd_r;
  assign pready            = rdy_r;
  assign pslverr           = err_r;

endmodule

// ==== eeprom_link_chk.sv ====
module eeprom_link_chk #(
  parameter int QUARTER_CYC = 7
) (
  input wire logic sys_clk,      // system clock
  input wire logic rst_b,        // async reset, active low
  input wire logic scl,          // serial clock
  input wire logic sda,          // resolved data line
  input wire logic sdaOeHost,    // host pulls data low
  input wire logic sdaOeDev,     // device pulls data low
  input wire logic writeInhibit, // write-inhibit level
  input wire logic lockState     // lower half locked
);
  timeunit 1ns;
  timeprecision 1ns;
  // ack plus eight zero bits spans nine clock falls at most;
  // counted in falls, as the master may park the clock low
  localparam int OE_MAX = 10;
  logic       sdaQ_r;
  logic       sdaQ_nxt;
  logic       busBusy_r;
  logic       busBusy_nxt;
  logic [3:0] stopAge_r;
  logic [3:0] stopAge_nxt;
  logic       sclQ_r;
  logic       sclQ_nxt;
  logic [3:0] oeAge_r;
  logic [3:0] oeAge_nxt;
  logic       startNow;
  logic       stopNow;

  always_comb begin
    startNow = scl && sdaQ_r && !sda;
    stopNow = scl && !sdaQ_r && sda;
    sdaQ_nxt = sda;
    busBusy_nxt = startNow || (busBusy_r && !stopNow);
    stopAge_nxt = stopNow ? 4'h0 : stopAge_r + {3'h0, stopAge_r != 4'hF};
    sclQ_nxt = scl;
    oeAge_nxt = sdaOeDev ? oeAge_r + {3'h0, sclQ_r && !scl && oeAge_r != 4'hF} : 4'h0;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdaQ_r <= 1'h1;
      busBusy_r <= 1'h0;
      stopAge_r <= 4'hF;
      sclQ_r <= 1'h1;
      oeAge_r <= 4'h0;
    end else begin
      sclQ_r <= sclQ_nxt;
      sdaQ_r <= sdaQ_nxt;
      busBusy_r <= busBusy_nxt;
      stopAge_r <= stopAge_nxt;
      oeAge_r <= oeAge_nxt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_sclHeld;
    scl [*3] ##[1:QUARTER_CYC] !scl;
  endsequence

  property p_startHold;
    s_start |-> s_sclHeld;
  endproperty
  property p_devIdle;
    !busBusy_r |-> !sdaOeDev;
  endproperty
  property p_oeEdge;
    $changed(sdaOeDev) |-> !scl;
  endproperty
  property p_oeBound;
    sdaOeDev |-> oeAge_r < OE_MAX;
  endproperty
  property p_lockHold;
    lockState |=> lockState;
  endproperty
  property p_lockInh;
    $rose(lockState) |-> !writeInhibit;
  endproperty
  property p_lockStop;
    $rose(lockState) |-> stopAge_r < 4'h8;
  endproperty
  property p_resetInit;
    $rose(rst_b) |-> scl && !sdaOeHost && !sdaOeDev && !lockState;
  endproperty

  a_startHold: assert property (p_startHold)
    else $error("clock not held through start");
  a_devIdle: assert property (p_devIdle)
    else $error("device drives an idle bus");
  a_oeEdge: assert property (p_oeEdge)
    else $error("device data changed with clock high");
  a_oeBound: assert property (p_oeBound)
    else $error("device did not release for ack slot");
  a_lockHold: assert property (p_lockHold)
    else $error("lock flag cleared");
  a_lockInh: assert property (p_lockInh)
    else $error("lock set with inhibit high");
  a_lockStop: assert property (p_lockStop)
    else $error("lock set away from a stop");
  a_resetInit: assert property (p_resetInit)
    else $error("bad state after reset");
endmodule

// ==== testbench.sv ====
`include "eeprom_link_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [4:0] cmd;  // command bits
    logic [7:0] tx;   // byte to send
    logic [7:0] exp;  // read data, or nack of a send
  } row_t;
  localparam int NROW = 43;
  logic        sys_clk = 1'h0;
  logic        rst_b = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lockState;
  logic [31:0] stat;
  logic [31:0] got;
  logic        err;
  int          n_fail = 0;
  int          check_count = 0;
  int          cyc = 0;
  // strap 101: memory AA/AB, protection 6A/6B, A0 wrong strap
  // unlocked protection read gives FF; upper half read back after lock
  row_t rows [NROW] = '{
    '{5'h01, 8'hAA, 8'h00}, '{5'h00, 8'hFF, 8'h00}, '{5'h00, 8'h5A, 8'h00},
    '{5'h00, 8'hC3, 8'h00}, '{5'h02, 8'h3C, 8'h00}, '{5'h01, 8'hAA, 8'h00},
    '{5'h00, 8'hFF, 8'h00}, '{5'h01, 8'hAB, 8'h00}, '{5'h0C, 8'h00, 8'h5A},
    '{5'h06, 8'h00, 8'hC3}, '{5'h01, 8'hAB, 8'h00}, '{5'h06, 8'h00, 8'h3C},
    '{5'h11, 8'hAA, 8'h00}, '{5'h10, 8'h80, 8'h00}, '{5'h12, 8'h77, 8'h01},
    '{5'h11, 8'hAA, 8'h00}, '{5'h10, 8'hFF, 8'h00}, '{5'h11, 8'hAB, 8'h00},
    '{5'h1C, 8'h00, 8'h5A}, '{5'h16, 8'h00, 8'hC3}, '{5'h03, 8'hA0, 8'h01},
    '{5'h03, 8'h2A, 8'h01}, '{5'h01, 8'h6B, 8'h00}, '{5'h06, 8'h00, 8'hFF},
    '{5'h01, 8'h6A, 8'h00}, '{5'h00, 8'h12, 8'h00},
    '{5'h02, 8'h34, 8'h00}, '{5'h03, 8'h6A, 8'h01}, '{5'h03, 8'h6B, 8'h01},
    '{5'h01, 8'hAA, 8'h00}, '{5'h00, 8'h00, 8'h00}, '{5'h02, 8'h99, 8'h01},
    '{5'h01, 8'hAA, 8'h00}, '{5'h00, 8'h00, 8'h00}, '{5'h01, 8'hAB, 8'h00},
    '{5'h06, 8'h00, 8'hC3}, '{5'h01, 8'hAA, 8'h00}, '{5'h00, 8'h80, 8'h00},
    '{5'h02, 8'h77, 8'h00}, '{5'h01, 8'hAA, 8'h00}, '{5'h00, 8'h80, 8'h00},
    '{5'h01, 8'hAB, 8'h00}, '{5'h06, 8'h00, 8'h77}
  };

  two_wire_if link ();

  eeprom_host #(
    .QUARTER_CYC(4)
  ) eeprom_host_i (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .link    (link.host),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  eeprom_dev eeprom_dev_i (
    .sys_clk      (sys_clk),
    .rst_b        (rst_b),
    .link         (link.dev),
    .chipSelStrap (3'h5),
    .lockState    (lockState)
  );

  eeprom_link_chk #(
    .QUARTER_CYC(4)
  ) eeprom_link_chk_i (
    .sys_clk      (sys_clk),
    .rst_b        (rst_b),
    .scl          (link.scl),
    .sda          (link.sda),
    .sdaOeHost    (link.sdaOeHost),
    .sdaOeDev     (link.sdaOeDev),
    .writeInhibit (link.writeInhibit),
    .lockState    (lockState)
  );

  always #50 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // called right after a rising edge; ends one edge after the answer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    // only the cycle ceiling ends a hung wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'h1);
    stat = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask

  // one byte on the link, then poll until the host is idle again
  task automatic op(input logic [4:0] c, input logic [7:0] b);
    if (!c[`CMD_READ_BIT]) apb(1'h1, `OFS_TX, {24'h0, b});
    apb(1'h1, `OFS_CMD, {27'h0, c});
    do begin
      apb(1'h0, `OFS_STATUS, 32'h0);
    end while (stat[`STAT_BUSY_BIT] !== 1'h0);
    if (c[`CMD_STOP_BIT]) begin
      chk(32'(link.scl), 32'h1);
      chk(32'(link.sda), 32'h1);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    chk(32'(link.scl), 32'h1);
    chk(32'(link.sdaOeDev), 32'h0);
    chk(32'(lockState), 32'h0);
    rst_b <= 1'h1;
    @(posedge sys_clk);
    for (int i = 0; i < NROW; i++) begin
      if (i == 24) chk(32'(lockState), 32'h0);
      op(rows[i].cmd, rows[i].tx);
      got = rows[i].cmd[2] ? {24'h0, stat[15:8]} : {31'h0, stat[1]};
      chk(got, {24'h0, rows[i].exp});
    end
    chk(32'(lockState), 32'h1);
    // unmapped register: error, no data
    apb(1'h0, 8'h0C, 32'h0);
    chk(32'(err), 32'h1);
    chk(stat, 32'h0);
    end_sim();
  end
endmodule
